// >>> verilog/cps_core_state.v
// Purpose: Program counter, A, X, both stack pointers and address
//          generation of an 8-bit core, sequenced per command
// Assumes: Data RAM with one-cycle read latency on the same clock
// Notes:   One command at a time; CMD_VALID is ignored while BUSY
`timescale 1ns/10ps
`include "cps_regs.vh"

module cps_core_state #(
	parameter DW = `CPS_DW
) (
	input  wire                    CLK,
	input  wire                    RSTN,
	input  wire                    CMD_VALID,
	input  wire [`CPS_CMD_W-1:0]   CMD,
	input  wire [`CPS_MODE_W-1:0]  OP_MODE,
	input  wire                    OP_LEN,
	input  wire [DW-1:0]           OPERAND,
	input  wire [`CPS_PC_W-1:0]    TARGET,
	input  wire                    FLAG_C,
	input  wire                    FLAG_Z,
	input  wire [DW-1:0]           RAM_RDATA,
	output reg  [`CPS_PC_W-1:0]    PC,
	output reg  [DW-1:0]           ACC,
	output reg  [DW-1:0]           IDX,
	output reg  [DW-1:0]           CSP,
	output reg  [DW-1:0]           DSP,
	output reg                     CARRY,
	output reg                     ZERO,
	output reg                     IRQ_EN,
	output reg  [DW-1:0]           RAM_ADDR,
	output reg  [DW-1:0]           RAM_WDATA,
	output reg                     RAM_WE,
	output reg                     RAM_RE,
	output reg                     BUSY,
	output reg                     DONE
);

	// ****************************************
	// States
	// ****************************************
	localparam [6:0] S_IDLE  = 7'h01;
	localparam [6:0] S_WR2   = 7'h02;
	localparam [6:0] S_WAIT1 = 7'h04;
	localparam [6:0] S_GOT1  = 7'h08;
	localparam [6:0] S_WAIT2 = 7'h10;
	localparam [6:0] S_GOT2  = 7'h20;
	localparam [6:0] S_FIN   = 7'h40;

	// ****************************************
	// Functions
	// ****************************************
	// Operand address for direct and indexed modes
	function [DW-1:0] eff_addr;
		input [`CPS_MODE_W-1:0] mode;
		input [DW-1:0]          base;
		input [DW-1:0]          index;
		begin
			if (mode == `CPS_MODE_INDEX) begin
				eff_addr = base + index;
			end else begin
				eff_addr = base;
			end
		end
	endfunction

	// Mod-256 add with no carry out
	function [DW-1:0] wrap_add;
		input [DW-1:0] v;
		input [DW-1:0] d;
		begin
			wrap_add = v + d;
		end
	endfunction

	// Mod-256 subtract with no borrow
	function [DW-1:0] wrap_sub;
		input [DW-1:0] v;
		input [DW-1:0] d;
		begin
			wrap_sub = v - d;
		end
	endfunction

	// ****************************************
	// Reset release
	// ****************************************
	reg rst_s1_r;
	reg rst_s2_r;
	wire rstn_i;

	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// Release is synchronous; every flop leaves reset on one edge
	assign rstn_i = rst_s2_r;

	// ****************************************
	// Sequencer
	// ****************************************
	reg [6:0]             state_r;
	reg [`CPS_CMD_W-1:0]  cmd_r;
	reg [DW-1:0]          hold_r;
	wire                  take;
	wire [DW-1:0]         opnd_addr;
	wire [DW-1:0]         csp_dn;
	wire [DW-1:0]         dsp_dn;
	wire [DW-1:0]         rec_hi;
	wire                  is_mem;

	// Requests during a command are dropped, not queued
	assign take      = CMD_VALID && !BUSY && (state_r == S_IDLE);
	assign opnd_addr = eff_addr(OP_MODE, OPERAND, IDX);
	assign csp_dn    = wrap_sub(CSP, `CPS_STEP_ONE);
	assign dsp_dn    = wrap_sub(DSP, `CPS_STEP_ONE);
	assign is_mem    = (OP_MODE != `CPS_MODE_CONST);
	// Flags ride in the high byte beside pc[13:8]
	assign rec_hi    = {CARRY, ZERO, PC[`CPS_PC_HI_MSB:`CPS_PC_HI_LSB]};

	always @(posedge CLK or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r   <= S_IDLE;
			cmd_r     <= `CPS_CMD_ADV;
			hold_r    <= `CPS_BYTE_RST;
			PC        <= `CPS_PC_RST;
			ACC       <= `CPS_BYTE_RST;
			IDX       <= `CPS_BYTE_RST;
			CSP       <= `CPS_SP_RST;
			DSP       <= `CPS_SP_RST;
			CARRY     <= 1'b0;
			ZERO      <= 1'b0;
			IRQ_EN    <= 1'b0;
			RAM_ADDR  <= `CPS_BYTE_RST;
			RAM_WDATA <= `CPS_BYTE_RST;
			RAM_WE    <= 1'b0;
			RAM_RE    <= 1'b0;
			BUSY      <= 1'b0;
			DONE      <= 1'b0;
		end else begin
			case (state_r)
			S_IDLE: begin
				DONE <= 1'b0;
				if (take) begin
					// Kept for the later steps of long commands
					cmd_r   <= CMD;
					BUSY    <= 1'b1;
					state_r <= S_FIN;
					case (CMD)
					`CPS_CMD_ADV: begin
						// Low byte only; carry out is dropped
						PC[`CPS_PC_LO_MSB:0] <= OP_LEN ?
							wrap_add(PC[`CPS_PC_LO_MSB:0], `CPS_STEP_TWO) :
							wrap_add(PC[`CPS_PC_LO_MSB:0], `CPS_STEP_ONE);
					end
					`CPS_CMD_PAGE: begin
						PC[`CPS_PC_HI_MSB:`CPS_PC_HI_LSB] <=
							PC[`CPS_PC_HI_MSB:`CPS_PC_HI_LSB] +
							`CPS_PAGE_ONE;
					end
					`CPS_CMD_JUMP: begin
						PC <= TARGET;
					end
					`CPS_CMD_CALL, `CPS_CMD_INTACK: begin
						if (CMD == `CPS_CMD_INTACK) begin
							IRQ_EN <= 1'b0;
						end
						RAM_ADDR  <= CSP;
						RAM_WDATA <= PC[`CPS_PC_LO_MSB:0];
						RAM_WE    <= 1'b1;
						CSP       <= wrap_add(CSP, `CPS_STEP_ONE);
						state_r   <= S_WR2;
					end
					`CPS_CMD_RET, `CPS_CMD_INTERRUPT_RETURN_OP: begin
						CSP      <= csp_dn;
						RAM_ADDR <= csp_dn;
						RAM_RE   <= 1'b1;
						state_r  <= S_WAIT1;
					end
					`CPS_CMD_PUSH_A, `CPS_CMD_PUSH_X: begin
						// Pointer at 0 wraps, so the byte lands at 0xFF
						DSP       <= dsp_dn;
						RAM_ADDR  <= dsp_dn;
						RAM_WDATA <= (CMD == `CPS_CMD_PUSH_A) ? ACC : IDX;
						RAM_WE    <= 1'b1;
					end
					`CPS_CMD_POP_A, `CPS_CMD_POP_X: begin
						RAM_ADDR <= DSP;
						RAM_RE   <= 1'b1;
						state_r  <= S_WAIT1;
					end
					`CPS_CMD_SWAP_DSP: begin
						DSP <= ACC;
						ACC <= DSP;
					end
					`CPS_CMD_LOAD_PSP: begin
						CSP <= ACC;
					end
					`CPS_CMD_LOAD_A, `CPS_CMD_LOAD_X: begin
						if (is_mem) begin
							RAM_ADDR <= opnd_addr;
							RAM_RE   <= 1'b1;
							state_r  <= S_WAIT1;
						end else if (CMD == `CPS_CMD_LOAD_A) begin
							ACC <= OPERAND;
						end else begin
							IDX <= OPERAND;
						end
					end
					`CPS_CMD_STORE_A: begin
						// Constant mode has no address; nothing stored
						if (is_mem) begin
							RAM_ADDR  <= opnd_addr;
							RAM_WDATA <= ACC;
							RAM_WE    <= 1'b1;
						end
					end
					`CPS_CMD_SWAP_X: begin
						ACC <= IDX;
						IDX <= ACC;
					end
					`CPS_CMD_EI: begin
						IRQ_EN <= 1'b1;
					end
					`CPS_CMD_DI: begin
						IRQ_EN <= 1'b0;
					end
					`CPS_CMD_FLAGS: begin
						CARRY <= FLAG_C;
						ZERO  <= FLAG_Z;
					end
					default: begin
						state_r <= S_FIN;
					end
					endcase
				end
			end
			S_WR2: begin
				// Second byte of the return record, then branch
				RAM_ADDR  <= CSP;
				RAM_WDATA <= rec_hi;
				RAM_WE    <= 1'b1;
				CSP       <= wrap_add(CSP, `CPS_STEP_ONE);
				PC        <= TARGET;
				state_r   <= S_FIN;
			end
			S_WAIT1: begin
				// RAM samples the address during this cycle
				RAM_RE  <= 1'b0;
				state_r <= S_GOT1;
			end
			S_GOT1: begin
				state_r <= S_FIN;
				case (cmd_r)
				`CPS_CMD_RET, `CPS_CMD_INTERRUPT_RETURN_OP: begin
					hold_r   <= RAM_RDATA;
					CSP      <= csp_dn;
					RAM_ADDR <= csp_dn;
					RAM_RE   <= 1'b1;
					state_r  <= S_WAIT2;
				end
				`CPS_CMD_POP_A: begin
					ACC <= RAM_RDATA;
					DSP <= wrap_add(DSP, `CPS_STEP_ONE);
				end
				`CPS_CMD_POP_X: begin
					IDX <= RAM_RDATA;
					DSP <= wrap_add(DSP, `CPS_STEP_ONE);
				end
				`CPS_CMD_LOAD_A: begin
					ACC <= RAM_RDATA;
				end
				`CPS_CMD_LOAD_X: begin
					IDX <= RAM_RDATA;
				end
				default: begin
					state_r <= S_FIN;
				end
				endcase
			end
			S_WAIT2: begin
				RAM_RE  <= 1'b0;
				state_r <= S_GOT2;
			end
			S_GOT2: begin
				// Plain return leaves carry and zero as they are
				PC <= {hold_r[`CPS_REC_HI_MSB:0], RAM_RDATA};
				if (cmd_r == `CPS_CMD_INTERRUPT_RETURN_OP) begin
					CARRY  <= hold_r[`CPS_REC_C_BIT];
					ZERO   <= hold_r[`CPS_REC_Z_BIT];
					IRQ_EN <= 1'b1;
				end
				state_r <= S_FIN;
			end
			S_FIN: begin
				// Strobes drop here so no byte is written twice
				RAM_WE  <= 1'b0;
				RAM_RE  <= 1'b0;
				BUSY    <= 1'b0;
				DONE    <= 1'b1;
				state_r <= S_IDLE;
			end
			default: begin
				RAM_WE  <= 1'b0;
				RAM_RE  <= 1'b0;
				BUSY    <= 1'b0;
				state_r <= S_IDLE;
			end
			endcase
		end
	end

endmodule

// >>> common/cps_regs.vh
// Purpose: Constants for the core program-counter and stack block
// Assumes: Included by its bare name from the design file
// Notes:   Command codes are the encoding on the CMD port, mode codes on OP_MODE
`ifndef CPS_REGS_VH
`define CPS_REGS_VH

// ****************************************
// Widths
// ****************************************
`define CPS_PC_W        14
`define CPS_PC_LO_W     8
`define CPS_PC_HI_W     6
`define CPS_DW          8
`define CPS_CMD_W       5
`define CPS_MODE_W      2

// ****************************************
// Reset values
// ****************************************
`define CPS_PC_RST      14'h0000
`define CPS_SP_RST      8'h00
`define CPS_BYTE_RST    8'h00

// ****************************************
// Pointer steps and PC field positions
// ****************************************
`define CPS_STEP_ONE    8'h01
`define CPS_STEP_TWO    8'h02
`define CPS_PAGE_ONE    6'h01
`define CPS_PC_LO_MSB   7
`define CPS_PC_HI_LSB   8
`define CPS_PC_HI_MSB   13

// ****************************************
// Saved record: byte 1 = {carry, zero, pc[13:8]}
// ****************************************
`define CPS_REC_C_BIT   7
`define CPS_REC_Z_BIT   6
`define CPS_REC_HI_MSB  5

// ****************************************
// Commands
// ****************************************
`define CPS_CMD_ADV       5'h00
`define CPS_CMD_PAGE      5'h01
`define CPS_CMD_JUMP      5'h02
`define CPS_CMD_CALL      5'h03
`define CPS_CMD_INTACK    5'h04
`define CPS_CMD_RET       5'h05
`define CPS_CMD_INTERRUPT_RETURN_OP      5'h06
`define CPS_CMD_PUSH_A    5'h07
`define CPS_CMD_PUSH_X    5'h08
`define CPS_CMD_POP_A     5'h09
`define CPS_CMD_POP_X     5'h0A
`define CPS_CMD_SWAP_DSP  5'h0B
`define CPS_CMD_LOAD_PSP  5'h0C
`define CPS_CMD_LOAD_A    5'h0D
`define CPS_CMD_LOAD_X    5'h0E
`define CPS_CMD_STORE_A   5'h0F
`define CPS_CMD_SWAP_X    5'h10
`define CPS_CMD_EI        5'h11
`define CPS_CMD_DI        5'h12
`define CPS_CMD_FLAGS     5'h13

// ****************************************
// Operand address modes
// ****************************************
`define CPS_MODE_CONST  2'h0
`define CPS_MODE_DIRECT 2'h1
`define CPS_MODE_INDEX  2'h2

`endif

// >>> dv/cps_ram_model.sv
// Purpose: Data RAM on the far side of the core state block
// Assumes: Synchronous read, data valid one cycle after the read strobe
// Notes:   Stale read data is inverted every cycle, so on every second idle cycle it matches the last read again
`timescale 1ns/10ps
module cps_ram_model (
	input  wire logic       clk,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       we,
	input  wire logic       re,
	output logic      [7:0] rdata
);
	logic [7:0] mem [0:255];

	initial begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		rdata = 8'h00;
	end

	always @(posedge clk) begin
		if (we)
			mem[addr] <= wdata;
		rdata <= re ? mem[addr] : ~rdata;
	end
endmodule

// >>> dv/cps_core_state_monitor.sv
// Purpose: Port checker for cps_core_state
// Assumes: One command at a time, RAM read latency of one cycle
// Notes:   Cycle counts follow the command walk of the block
`timescale 1ns/10ps
module cps_core_state_monitor (
	input wire logic        CLK,
	input wire logic        RSTN,
	input wire logic        CMD_VALID,
	input wire logic [4:0]  CMD,
	input wire logic [1:0]  OP_MODE,
	input wire logic        OP_LEN,
	input wire logic [7:0]  OPERAND,
	input wire logic [7:0]  RAM_RDATA,
	input wire logic [13:0] PC,
	input wire logic [7:0]  ACC,
	input wire logic [7:0]  IDX,
	input wire logic [7:0]  CSP,
	input wire logic [7:0]  DSP,
	input wire logic        CARRY,
	input wire logic        ZERO,
	input wire logic        IRQ_EN,
	input wire logic [7:0]  RAM_ADDR,
	input wire logic [7:0]  RAM_WDATA,
	input wire logic        RAM_WE,
	input wire logic        RAM_RE,
	input wire logic        BUSY,
	input wire logic        DONE
);
	wire take = CMD_VALID && !BUSY;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	// ****
	// Call stack record steps
	// ****
	sequence s_save;
		RAM_WE && RAM_ADDR == $past(CSP) && RAM_WDATA == $past(PC[7:0])
		##1 RAM_WE && RAM_ADDR == $past(CSP, 2) + 8'h01 &&
		RAM_WDATA == {$past(CARRY, 2), $past(ZERO, 2), $past(PC[13:8], 2)}
		##1 DONE && CSP == $past(CSP, 3) + 8'h02;
	endsequence
	sequence s_load;
		RAM_RE && RAM_ADDR == $past(CSP) - 8'h01
		##2 RAM_RE && RAM_ADDR == $past(CSP, 3) - 8'h02
		##3 DONE && CSP == $past(CSP, 6) - 8'h02;
	endsequence

	// ****
	// Assertions
	// ****
	a_adv_low_wrap: assert property (
		take && CMD == 5'h00 |=> PC[13:8] == $past(PC[13:8]) &&
		PC[7:0] == $past(PC[7:0]) + ($past(OP_LEN) ? 8'h02 : 8'h01))
		else $error("adv step wrong");
	a_page_high: assert property (
		take && CMD == 5'h01 |=> PC == {$past(PC[13:8]) + 6'h01,
		$past(PC[7:0])}) else $error("page step wrong");
	a_call_save: assert property (
		take && CMD == 5'h03 |=> s_save) else $error("call save wrong");
	a_intack_save: assert property (
		take && CMD == 5'h04 |=> !IRQ_EN ##0 s_save)
		else $error("intack save wrong");
	a_ret_keeps: assert property (
		take && CMD == 5'h05 |=> s_load ##0 CARRY == $past(CARRY, 6) &&
		ZERO == $past(ZERO, 6)) else $error("ret wrong");
	a_interrupt_return_op_order: assert property (
		take && CMD == 5'h06 && !IRQ_EN |=> s_load and
		(!IRQ_EN [*4] ##1 IRQ_EN [*2])) else $error("interrupt_return_op order wrong");
	a_push_pre: assert property (
		take && CMD == 5'h07 |=> RAM_WE && DSP == $past(DSP) - 8'h01 &&
		RAM_ADDR == DSP && RAM_WDATA == $past(ACC)) else $error("push wrong");
	a_pop_post: assert property (
		take && CMD == 5'h09 |=> RAM_RE && RAM_ADDR == $past(DSP) ##2
		ACC == $past(RAM_RDATA) && DSP == $past(DSP, 3) + 8'h01 ##1 DONE)
		else $error("pop wrong");
	a_index_sum: assert property (
		take && CMD == 5'h0D && OP_MODE == 2'h2 |=> RAM_RE &&
		RAM_ADDR == $past(OPERAND) + $past(IDX) ##3 DONE)
		else $error("indexed address wrong");
endmodule

// >>> dv/test_cpu_pc_stack_and_addressing.sv
// Purpose: Self-checking bench for cps_core_state
// Assumes: RAM model starts with each byte at its address xor 5A
// Notes:   Rows chain, each starts from the state the last one left
`timescale 1ns/10ps
module test_cpu_pc_stack_and_addressing;
	typedef struct packed {
		logic [4:0]  c;
		logic [1:0]  m;
		logic [7:0]  o;
		logic [13:0] p;
		logic [7:0]  a;
		logic [7:0]  d;
		logic [7:0]  s;
	} cps_row_t;
	logic        CLK, RSTN, CMD_VALID, OP_LEN, FLAG_C, FLAG_Z;
	logic        CARRY, ZERO, IRQ_EN, RAM_WE, RAM_RE, BUSY, DONE;
	logic [4:0]  CMD;
	logic [1:0]  OP_MODE;
	logic [13:0] TARGET, PC;
	logic [7:0]  OPERAND, RAM_RDATA, ACC, IDX, CSP, DSP;
	logic [7:0]  RAM_ADDR, RAM_WDATA;
	int          failures;
	int          compares;
	cps_row_t    rows [16] = '{
		'{5'h00, 2'h1, 8'h00, 14'h0002, 8'h00, 8'h00, 8'h00},
		'{5'h00, 2'h0, 8'h00, 14'h0003, 8'h00, 8'h00, 8'h00},
		'{5'h0D, 2'h0, 8'h10, 14'h0003, 8'h10, 8'h00, 8'h00},
		'{5'h07, 2'h0, 8'h00, 14'h0003, 8'h10, 8'hFF, 8'h00},
		'{5'h0C, 2'h0, 8'h00, 14'h0003, 8'h10, 8'hFF, 8'h10},
		'{5'h0E, 2'h0, 8'h03, 14'h0003, 8'h10, 8'hFF, 8'h10},
		'{5'h0D, 2'h2, 8'h10, 14'h0003, 8'h49, 8'hFF, 8'h10},
		'{5'h0D, 2'h1, 8'hFF, 14'h0003, 8'h10, 8'hFF, 8'h10},
		'{5'h09, 2'h0, 8'h00, 14'h0003, 8'h10, 8'h00, 8'h10},
		'{5'h0B, 2'h0, 8'h00, 14'h0003, 8'h00, 8'h10, 8'h10},
		'{5'h02, 2'h0, 8'hFF, 14'h01FF, 8'h00, 8'h10, 8'h10},
		'{5'h00, 2'h1, 8'h00, 14'h0101, 8'h00, 8'h10, 8'h10},
		'{5'h01, 2'h0, 8'h00, 14'h0201, 8'h00, 8'h10, 8'h10},
		'{5'h03, 2'h0, 8'hA5, 14'h01A5, 8'h00, 8'h10, 8'h12},
		'{5'h05, 2'h0, 8'h00, 14'h0201, 8'h00, 8'h10, 8'h10},
		'{5'h10, 2'h0, 8'h00, 14'h0201, 8'h03, 8'h10, 8'h10}
	};

	cps_core_state i_dut (.CLK(CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID),
		.CMD(CMD), .OP_MODE(OP_MODE), .OP_LEN(OP_LEN), .OPERAND(OPERAND),
		.TARGET(TARGET), .FLAG_C(FLAG_C), .FLAG_Z(FLAG_Z),
		.RAM_RDATA(RAM_RDATA), .PC(PC), .ACC(ACC), .IDX(IDX), .CSP(CSP),
		.DSP(DSP), .CARRY(CARRY), .ZERO(ZERO), .IRQ_EN(IRQ_EN),
		.RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA), .RAM_WE(RAM_WE),
		.RAM_RE(RAM_RE), .BUSY(BUSY), .DONE(DONE));
	cps_ram_model i_ram (.clk(CLK), .addr(RAM_ADDR), .wdata(RAM_WDATA),
		.we(RAM_WE), .re(RAM_RE), .rdata(RAM_RDATA));

	// ****
	// Tasks
	// ****
	task automatic check(input string name, input logic [15:0] got, exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Flags and jump target ride on the operand byte
	task automatic run(input logic [4:0] c, input logic [1:0] m,
			input logic [7:0] o);
		CMD = c;
		OP_MODE = m;
		OP_LEN = m[0];
		OPERAND = o;
		TARGET = {6'h01, o};
		FLAG_C = o[1];
		FLAG_Z = o[0];
		CMD_VALID = 1'b1;
		@(posedge CLK);
		#1 CMD_VALID = 1'b0;
		for (int n = 0; n < 8 && DONE !== 1'b1; n++) begin
			@(posedge CLK);
			#1;
		end
	endtask

	task automatic reset_and_check();
		RSTN = 1'b0;
		repeat (2) @(posedge CLK);
		#1 RSTN = 1'b1;
		repeat (3) @(posedge CLK);
		#1 check("pc", PC, 14'h0000);
		check("csp", CSP, 8'h00);
		check("dsp", DSP, 8'h00);
		$display("reset test done");
	endtask

	// ****
	// Stimulus
	// ****
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	initial begin
		#20000;
		failures++;
		complete_run();
	end

	initial begin
		{CMD_VALID, CMD, OP_MODE, OP_LEN, OPERAND} = '0;
		{TARGET, FLAG_C, FLAG_Z, RSTN} = '0;
		failures = 0;
		compares = 0;
		#1 reset_and_check();
		foreach (rows[i]) begin
			run(rows[i].c, rows[i].m, rows[i].o);
			check("pc", PC, rows[i].p);
			check("acc", ACC, rows[i].a);
			check("dsp", DSP, rows[i].d);
			check("csp", CSP, rows[i].s);
			check("done", {BUSY, DONE}, 2'h1);
		end
		check("idx", IDX, 8'h00);
		$display("row tests done");
		run(5'h11, 2'h0, 8'h00);
		run(5'h13, 2'h0, 8'h03);
		run(5'h04, 2'h0, 8'h40);
		check("irq", IRQ_EN, 1'b0);
		check("lo", i_ram.mem[8'h10], 8'h01);
		check("hi", i_ram.mem[8'h11], 8'hC2);
		run(5'h13, 2'h0, 8'h00);
		run(5'h06, 2'h0, 8'h00);
		check("interrupt_return_op", {CARRY, ZERO, IRQ_EN}, 3'h7);
		check("pc", PC, 14'h0201);
		run(5'h03, 2'h0, 8'h00);
		run(5'h13, 2'h0, 8'h00);
		run(5'h05, 2'h0, 8'h00);
		check("flags", {CARRY, ZERO}, 2'h0);
		check("csp", CSP, 8'h10);
		$display("interrupt tests done");
		run(5'h0E, 2'h1, 8'h20);
		check("idx", IDX, 8'h7A);
		run(5'h08, 2'h0, 8'h00);
		check("dsp", DSP, 8'h0F);
		check("push x", i_ram.mem[8'h0F], 8'h7A);
		run(5'h0F, 2'h2, 8'h10);
		check("store x", i_ram.mem[8'h8A], 8'h03);
		run(5'h0F, 2'h1, 8'h30);
		check("store d", i_ram.mem[8'h30], 8'h03);
		run(5'h0E, 2'h0, 8'h55);
		run(5'h0A, 2'h0, 8'h00);
		check("pop x", IDX, 8'h7A);
		check("dsp", DSP, 8'h10);
		run(5'h12, 2'h0, 8'h00);
		check("irq", IRQ_EN, 1'b0);
		run(5'h1F, 2'h0, 8'h00);
		check("done", {BUSY, DONE}, 2'h1);
		check("pc", PC, 14'h0201);
		$display("data stack tests done");
		reset_and_check();
		complete_run();
	end
endmodule

bind cps_core_state cps_core_state_monitor i_mon (.CLK(CLK), .RSTN(RSTN),
	.CMD_VALID(CMD_VALID), .CMD(CMD), .OP_MODE(OP_MODE), .OP_LEN(OP_LEN),
	.OPERAND(OPERAND), .RAM_RDATA(RAM_RDATA), .PC(PC), .ACC(ACC),
	.IDX(IDX), .CSP(CSP), .DSP(DSP), .CARRY(CARRY), .ZERO(ZERO),
	.IRQ_EN(IRQ_EN), .RAM_ADDR(RAM_ADDR), .RAM_WDATA(RAM_WDATA),
	.RAM_WE(RAM_WE), .RAM_RE(RAM_RE), .BUSY(BUSY), .DONE(DONE));
